/* File: ppf_top.sv */
// palette lookup and frame fetch base address block with AHB-Lite register slave
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// R1: each dot's value indexes a palette entry; that entry's value is output
// R2: gradation numbers 0..15, ends are white and black, 14 shades between
// R3: dot data is 1, 2 or 4 bits, chosen by the depth select field
// R4: shades go to frame shading stage; thin-film mode bypasses it directly
// R5: palette and base registers clear on power-on reset, hold on manual reset
// R6: palette entries keep bits 11..0; bits 15..12 ignore writes, read zero
// R7: software programs only the entries used by the selected depth
// R8: monochrome/reflective modes use palette bits 3..0 only
// R9: thin-film mode: blue 1..0, green 3..2, red 5..4
// R10: passive colour mode: blue 3..0, green 7..4, red 11..8
// R11: upper base is low and high 16-bit halves of a 32-bit address
// R12: software keeps the upper base 16-byte aligned
// R13: high halves fully read/write, top three bits ignored for fetch
// R14: lower panel base formed from its own low and high halves
// R15: software keeps the lower base 16-byte aligned
// R16: software leaves base registers alone while the display runs
// R17: each fetch is a burst of four 32-bit beats, 16 bytes
// R18: fetch base keeps only the low 29 bits of joined halves
module ppf_top (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_por,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        i_word_valid,
    input  wire logic [31:0] i_word_data,
    output logic             o_word_ready,
    output logic             o_dot_valid,
    output logic      [11:0] o_dot_value,
    output logic             o_dot_to_shader,
    input  wire logic        i_dot_ready,
    input  wire logic        i_fetch_start,
    input  wire logic        i_fetch_lower,
    output logic             o_fetch_req,
    output logic      [28:0] o_fetch_addr,
    output logic      [1:0]  o_fetch_beat,
    input  wire logic        i_fetch_beat_ack
);
    // ==========================================================
    // helpers
    function automatic logic [28:0] join_base(input logic [15:0] hi, input logic [15:0] lo);
        logic [31:0] full;
        full = {hi, lo};
        return full[ppf_pkg::PHYS_ADDR_WIDTH-1:0];
    endfunction

    function automatic logic [3:0] dot_of(input logic [31:0] w, input logic [1:0] depth,
                                          input logic [4:0] pos);
        logic [3:0] r;
        r = 4'h0;
        case (depth)
            ppf_pkg::DEPTH_1BIT: r = {3'h0, w[pos]};
            ppf_pkg::DEPTH_2BIT: r = {2'h0, w[{pos[3:0], 1'b0} +: 2]};
            default:             r = w[{pos[2:0], 2'h0} +: 4];
        endcase
        return r;
    endfunction

    // bits a register keeps from a write; a read behind that write must see them
    function automatic logic [31:0] stored_mask(input logic [7:0] off);
        logic [31:0] m;
        m = 32'h0000_0000;
        if (off < ppf_pkg::UPPER_BASE_LOW_OFF)
            m = 32'h0000_0FFF;
        else if (off <= ppf_pkg::LOWER_BASE_HIGH_OFF)
            m = 32'h0000_FFFF;
        else if (off == ppf_pkg::DISPLAY_CONTROL_OFF)
            m = 32'h0000_003F;
        return m;
    endfunction

    // ==========================================================
    // register state
    logic [11:0] palette_reg [ppf_pkg::PALETTE_ENTRIES];
    logic [15:0] upper_low_reg;
    logic [15:0] upper_high_reg;
    logic [15:0] lower_low_reg;
    logic [15:0] lower_high_reg;
    logic [5:0]  control_reg;

    // ==========================================================
    // AHB-Lite slave: zero wait states, always OKAY
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    wire         accept  = hsel & htrans[1] & hready;
    wire  [7:0]  a_off   = {haddr[7:2], 2'h0};
    wire         w_pal   = wr_pend_reg & (wr_addr_reg < ppf_pkg::UPPER_BASE_LOW_OFF);
    wire  [3:0]  w_idx   = wr_addr_reg[5:2];

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= accept & hwrite;
            wr_addr_reg <= a_off;
        end
    end

    // manual reset holds the registers; only power-on clears them
    always_ff @(posedge i_clk) begin
        if (!i_nrst && i_por) begin                                                     // R5
            for (int i = 0; i < ppf_pkg::PALETTE_ENTRIES; i++)
                palette_reg[i] <= ppf_pkg::PALETTE_RESET;
            upper_low_reg  <= ppf_pkg::HALF_RESET;
            upper_high_reg <= ppf_pkg::HALF_RESET;
            lower_low_reg  <= ppf_pkg::HALF_RESET;
            lower_high_reg <= ppf_pkg::HALF_RESET;
            control_reg    <= ppf_pkg::CONTROL_RESET;
        end else if (i_nrst && wr_pend_reg) begin
            if (w_pal)
                palette_reg[w_idx] <= hwdata[11:0];                                      // R6
            case (wr_addr_reg)
                ppf_pkg::UPPER_BASE_LOW_OFF:  upper_low_reg  <= hwdata[15:0];          // R11
                ppf_pkg::UPPER_BASE_HIGH_OFF: upper_high_reg <= hwdata[15:0];          // R13
                ppf_pkg::LOWER_BASE_LOW_OFF:  lower_low_reg  <= hwdata[15:0];          // R14
                ppf_pkg::LOWER_BASE_HIGH_OFF: lower_high_reg <= hwdata[15:0];          // R14
                ppf_pkg::DISPLAY_CONTROL_OFF: control_reg    <= hwdata[5:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // fetch engine: bursts of four words from the selected base
    ppf_pkg::ppf_fetch_state_t state_reg;
    logic [28:0] addr_reg;
    logic [1:0]  beat_reg;
    wire  [28:0] upper_base = join_base(upper_high_reg, upper_low_reg);                 // R18
    wire  [28:0] lower_base = join_base(lower_high_reg, lower_low_reg);                 // R18
    wire         dual       = control_reg[ppf_pkg::DUAL_BIT];
    wire         lower_pick = dual & i_fetch_lower;
    wire  [28:0] start_base = lower_pick ? lower_base : upper_base;

    assign o_fetch_req  = (state_reg == ppf_pkg::PPF_BURST);
    assign o_fetch_addr = addr_reg;
    assign o_fetch_beat = beat_reg;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state_reg <= ppf_pkg::PPF_IDLE;
            addr_reg  <= 29'h0;
            beat_reg  <= 2'h0;
        end else begin
            case (state_reg)
                ppf_pkg::PPF_IDLE: begin
                    if (i_fetch_start) begin
                        state_reg <= ppf_pkg::PPF_BURST;
                        addr_reg  <= start_base;
                        beat_reg  <= 2'h0;
                    end
                end
                ppf_pkg::PPF_BURST: begin
                    if (i_fetch_beat_ack) begin
                        addr_reg <= addr_reg + 29'h4;                                   // R17
                        beat_reg <= beat_reg + 2'h1;
                        if (beat_reg == 2'(ppf_pkg::BURST_BEATS - 1))
                            state_reg <= ppf_pkg::PPF_IDLE;                            // R17
                    end
                end
                default: state_reg <= ppf_pkg::PPF_IDLE;
            endcase
        end
    end

    // ==========================================================
    // read path: data registered into the data phase
    logic [31:0] rdata_reg;
    wire  [3:0]  r_idx = a_off[5:2];
    wire  [31:0] status_word = {29'h0, beat_reg, o_fetch_req};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (a_off < ppf_pkg::UPPER_BASE_LOW_OFF)
            rd_mux = {20'h0, palette_reg[r_idx]};                                       // R6
        else case (a_off)
            ppf_pkg::UPPER_BASE_LOW_OFF:  rd_mux = {16'h0, upper_low_reg};
            ppf_pkg::UPPER_BASE_HIGH_OFF: rd_mux = {16'h0, upper_high_reg};             // R13
            ppf_pkg::LOWER_BASE_LOW_OFF:  rd_mux = {16'h0, lower_low_reg};
            ppf_pkg::LOWER_BASE_HIGH_OFF: rd_mux = {16'h0, lower_high_reg};
            ppf_pkg::DISPLAY_CONTROL_OFF: rd_mux = {26'h0, control_reg};
            ppf_pkg::FETCH_STATUS_OFF:    rd_mux = status_word;
            default:                      rd_mux = 32'h0000_0000;
        endcase
    end

    // a read right behind a write to the same register sees the written value
    wire  [31:0] keep_mask = stored_mask(a_off);
    wire         fwd_hit   = wr_pend_reg & (wr_addr_reg == a_off) & (keep_mask != 32'h0000_0000);
    wire  [31:0] rd_word   = fwd_hit ? (hwdata & keep_mask) : rd_mux;                   // R6
    always_ff @(posedge i_clk) begin
        if (!i_nrst)
            rdata_reg <= 32'h0000_0000;
        else if (accept && !hwrite)
            rdata_reg <= rd_word;
    end
    assign hrdata = rdata_reg;

    // ==========================================================
    // dot unpacking and palette lookup
    wire  [1:0]  depth     = control_reg[ppf_pkg::DEPTH_LSB +: 2];
    wire  [2:0]  mode      = control_reg[ppf_pkg::MODE_LSB +: 3];
    wire         thin_film = (mode == ppf_pkg::MODE_THIN_FILM);
    wire         stn_color = (mode == ppf_pkg::MODE_STN_COLOR);
    logic [4:0]  pos_reg;
    wire  [4:0]  last_pos  = (depth == ppf_pkg::DEPTH_1BIT) ? 5'h1F :
                             (depth == ppf_pkg::DEPTH_2BIT) ? 5'h0F : 5'h07;           // R3
    wire  [3:0]  dot       = dot_of(i_word_data, depth, pos_reg);                       // R3
    wire  [11:0] entry     = palette_reg[dot];                                          // R1
    // mode decides how much of the entry is meaningful
    wire  [11:0] value     = thin_film ? {6'h0, entry[5:0]} :                           // R9
                             stn_color ? entry :                                        // R10
                                         {8'h0, entry[3:0]};                            // R2 R8

    ppf_stream_if lookup ();
    ppf_stream_if panel ();
    assign lookup.valid  = i_word_valid;
    assign lookup.data   = value;
    assign lookup.bypass = thin_film;                                                   // R4
    wire   take          = lookup.valid & lookup.ready;
    assign o_word_ready  = take & (pos_reg == last_pos);

    always_ff @(posedge i_clk) begin
        if (!i_nrst)
            pos_reg <= 5'h00;
        else if (take)
            pos_reg <= (pos_reg == last_pos) ? 5'h00 : pos_reg + 5'h01;
    end

    ppf_skid_buffer u_buf (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .up     (lookup),
        .dn     (panel)
    );

    // stall from the panel side backs up into the word stream
    assign panel.ready     = i_dot_ready;
    assign o_dot_valid     = panel.valid;
    assign o_dot_value     = panel.data;
    assign o_dot_to_shader = panel.valid & ~panel.bypass;                               // R4

    // ==========================================================
    // checks
    a_burst_four_beats: assert property (@(posedge i_clk) disable iff (!i_nrst)         // R17
        (o_fetch_req && beat_reg == 2'h3 && i_fetch_beat_ack) |=> !o_fetch_req)
        else $error("burst did not end after four beats");
    a_base_start: assert property (@(posedge i_clk) disable iff (!i_nrst)               // R18
        ($rose(o_fetch_req) && !$past(lower_pick)) |->
            o_fetch_addr == $past(upper_base))
        else $error("fetch did not start at upper base");
    a_lower_start: assert property (@(posedge i_clk) disable iff (!i_nrst)              // R14
        ($rose(o_fetch_req) && $past(lower_pick)) |->
            o_fetch_addr == $past(lower_base))
        else $error("fetch did not start at lower base");
    a_pal_read_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)            // R6
        (accept && !hwrite && a_off < ppf_pkg::UPPER_BASE_LOW_OFF) |=> hrdata[31:12] == 20'h0)
        else $error("palette upper bits not zero");
    a_thin_bypass: assert property (@(posedge i_clk) disable iff (!i_nrst)              // R4
        (take && thin_film) |-> lookup.data[11:6] == 6'h0 && lookup.bypass)
        else $error("thin film value not bypassed");
    a_mono_width: assert property (@(posedge i_clk) disable iff (!i_nrst)               // R8
        (take && !thin_film && !stn_color) |-> lookup.data[11:4] == 8'h0)
        else $error("mono value wider than four bits");
    a_lookup_entry: assert property (@(posedge i_clk) disable iff (!i_nrst)             // R1
        (take && stn_color) |-> lookup.data == palette_reg[dot])
        else $error("lookup not from indexed entry");
    a_high_write: assert property (@(posedge i_clk) disable iff (!i_nrst)               // R13
        (wr_pend_reg && wr_addr_reg == ppf_pkg::UPPER_BASE_HIGH_OFF) |=>
            {16'h0000, upper_high_reg} == ($past(hwdata) & 32'h0000_FFFF))
        else $error("high half not stored whole");
    a_depth_dot: assert property (@(posedge i_clk) disable iff (!i_nrst)                // R3
        (depth == ppf_pkg::DEPTH_1BIT) |-> dot == {3'h0, 1'(i_word_data >> pos_reg)})
        else $error("one bit dot too wide");
    a_start_burst: assert property (@(posedge i_clk) disable iff (!i_nrst)              // R17
        (!o_fetch_req && i_fetch_start) |=> o_fetch_req)
        else $error("burst did not start");
    a_beat_step: assert property (@(posedge i_clk) disable iff (!i_nrst)                // R17
        (o_fetch_req && i_fetch_beat_ack && o_fetch_beat != 2'h3) |=>
            o_fetch_addr == $past(o_fetch_addr) + 29'h4)
        else $error("beat address did not step by one word");
    a_beat_wrap: assert property (@(posedge i_clk) disable iff (!i_nrst)                // R17
        !o_fetch_req |-> o_fetch_beat == 2'h0)
        else $error("beat index not at zero while idle");
    a_manual_hold: assert property (@(posedge i_clk)                                    // R5
        (!i_nrst && !i_por) |=> $stable(upper_high_reg) && $stable(palette_reg[0]))
        else $error("manual reset changed a register");
    a_por_clear: assert property (@(posedge i_clk)                                      // R5
        (!i_nrst && i_por) |=> upper_high_reg == 16'h0000 && palette_reg[5] == 12'h000)
        else $error("power-on reset left a register set");
endmodule
`default_nettype wire

/* File: ppf_pkg.sv */
// package: register map, field layout and encodings for palette and fetch base block
package ppf_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] PALETTE_BASE_OFF     = 8'h00;
    localparam logic [7:0] UPPER_BASE_LOW_OFF   = 8'h40;
    localparam logic [7:0] UPPER_BASE_HIGH_OFF  = 8'h44;
    localparam logic [7:0] LOWER_BASE_LOW_OFF   = 8'h48;
    localparam logic [7:0] LOWER_BASE_HIGH_OFF  = 8'h4C;
    localparam logic [7:0] DISPLAY_CONTROL_OFF  = 8'h50;
    localparam logic [7:0] FETCH_CONTROL_OFF    = 8'h54;
    localparam logic [7:0] FETCH_STATUS_OFF     = 8'h58;
    // ==========================================================
    // field layout
    localparam int PALETTE_ENTRIES  = 16;
    localparam int PALETTE_WIDTH    = 12;
    localparam int HALF_WIDTH       = 16;
    localparam int PHYS_ADDR_WIDTH  = 29;
    localparam int BURST_BEATS      = 4;
    localparam int BURST_ALIGN_BITS = 4;
    localparam int DEPTH_LSB        = 0;
    localparam int MODE_LSB         = 2;
    localparam int DUAL_BIT         = 5;
    localparam logic [15:0] HALF_RESET    = 16'h0000;
    localparam logic [11:0] PALETTE_RESET = 12'h000;
    localparam logic [5:0]  CONTROL_RESET = 6'h00;
    // ==========================================================
    // encodings
    localparam logic [1:0] DEPTH_1BIT = 2'h0;
    localparam logic [1:0] DEPTH_2BIT = 2'h1;
    localparam logic [1:0] DEPTH_4BIT = 2'h2;
    localparam logic [2:0] MODE_THIN_FILM = 3'h6;
    localparam logic [2:0] MODE_STN_COLOR = 3'h3;
    typedef enum logic [1:0] {PPF_IDLE, PPF_BURST} ppf_fetch_state_t;
endpackage

/* File: ppf_stream_if.sv */
// interface: valid/ready stream of palette output words
`timescale 1ns/10ps
`default_nettype none
interface ppf_stream_if;
    logic        valid;
    logic        ready;
    logic [11:0] data;
    logic        bypass;
    modport src (output valid, output data, output bypass, input ready);
    modport dst (input valid, input data, input bypass, output ready);
endinterface
`default_nettype wire

/* File: ppf_skid_buffer.sv */
// two-entry buffer between the palette lookup and the panel output
`timescale 1ns/10ps
`default_nettype none
module ppf_skid_buffer (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    ppf_stream_if.dst up,
    ppf_stream_if.src dn
);
    logic [12:0] slot_reg [2];
    logic [1:0]  count_reg;
    logic        rd_ptr_reg;
    logic        wr_ptr_reg;
    wire         push = up.valid & up.ready;
    wire         pop  = dn.valid & dn.ready;

    assign up.ready  = (count_reg != 2'h2);
    assign dn.valid  = (count_reg != 2'h0);
    assign dn.data   = slot_reg[rd_ptr_reg][11:0];
    assign dn.bypass = slot_reg[rd_ptr_reg][12];

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            count_reg  <= 2'h0;
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
        end else begin
            if (push)
                wr_ptr_reg <= ~wr_ptr_reg;
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge i_clk) begin
        if (push)
            slot_reg[wr_ptr_reg] <= {up.bypass, up.data};
    end
endmodule
`default_nettype wire

/* File: ppf_mem_model.sv */
// memory and panel partner: acks fetch beats and paces the panel side
`timescale 1ns/10ps
`default_nettype none
module ppf_mem_model (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_req,
    input  wire logic i_slow,
    output logic      o_ack,
    output logic      o_panel_ready
);
    logic [2:0] wait_reg;
    logic [1:0] pace_reg;
    // ==========================================================
    // beat acks
    // one ack per beat; a slow memory waits three cycles first
    always_ff @(posedge i_clk) begin
        if (!i_nrst || !i_req || o_ack) begin
            wait_reg <= 3'h0;
            o_ack    <= 1'b0;
        end else if (wait_reg == (i_slow ? 3'h3 : 3'h0)) begin
            o_ack <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 3'h1;
        end
    end
    // ==========================================================
    // panel pacing
    // a slow panel takes one dot in four, so the buffer fills up
    always_ff @(posedge i_clk) begin
        pace_reg <= i_nrst ? pace_reg + 2'h1 : 2'h0;
    end
    assign o_panel_ready = !i_slow || (pace_reg == 2'h3);
endmodule
`default_nettype wire

/* File: test_panel_palette_and_fetch_base.sv */
// testbench: registers, palette lookup and fetch bursts of the palette block
`timescale 1ns/10ps
`default_nettype none
module test_panel_palette_and_fetch_base;
    logic        i_clk, i_nrst, i_por, hsel, hwrite, i_word_valid, i_fetch_start, i_fetch_lower, slow;
    logic [31:0] haddr, hwdata, hrdata, i_word_data;
    logic [1:0]  htrans, o_fetch_beat;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, o_word_ready, o_dot_valid, o_dot_to_shader, i_dot_ready;
    logic        o_fetch_req, i_fetch_beat_ack;
    logic [11:0] o_dot_value;
    logic [28:0] o_fetch_addr;
    wire logic   hready;
    int          n_errors, checks;
    logic [12:0] dots[$];
    logic [30:0] beats[$];
    assign hready = hreadyout;

    ppf_top dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_por(i_por), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .i_word_valid(i_word_valid),
        .i_word_data(i_word_data), .o_word_ready(o_word_ready), .o_dot_valid(o_dot_valid),
        .o_dot_value(o_dot_value), .o_dot_to_shader(o_dot_to_shader), .i_dot_ready(i_dot_ready),
        .i_fetch_start(i_fetch_start), .i_fetch_lower(i_fetch_lower), .o_fetch_req(o_fetch_req),
        .o_fetch_addr(o_fetch_addr), .o_fetch_beat(o_fetch_beat), .i_fetch_beat_ack(i_fetch_beat_ack));
    ppf_mem_model partner (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(o_fetch_req), .i_slow(slow),
        .o_ack(i_fetch_beat_ack), .o_panel_ready(i_dot_ready));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // ==========================================================
    // monitors of dots and fetch beats
    always @(posedge i_clk) begin
        if (o_dot_valid === 1'b1 && i_dot_ready === 1'b1) dots.push_back({o_dot_to_shader, o_dot_value});
        if (o_fetch_req === 1'b1 && i_fetch_beat_ack === 1'b1) beats.push_back({o_fetch_beat, o_fetch_addr});
    end
    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] off, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, off};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge i_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge i_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] off, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, off, d, r);
    endtask
    task automatic rdchk(input logic [7:0] off, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, off, 32'h00000000, r);
        check(r, e);
    endtask
    task automatic do_reset(input logic por);
        i_nrst <= 1'b0;
        i_por <= por;
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        i_por <= 1'b0;
        @(posedge i_clk);
    endtask
    // palette value per mode, kept inside the bits that mode uses
    function automatic logic [11:0] pval(input logic [2:0] md, input int k);
        logic [11:0] v;
        v = 12'(k);
        if (md == 3'h6) return {6'h00, v[1:0], ~v[1:0], v[3:2]};
        if (md == 3'h3) return {v[3:0], ~v[3:0], v[3:0] ^ 4'h5};
        return 12'h00F - v;
    endfunction
    // ==========================================================
    // scenarios
    task automatic test_regs();
        for (int k = 0; k < 20; k++) rdchk(8'(4 * k), 32'h00000000);
        rdchk(8'h60, 32'h00000000);
        check({30'h00000000, hreadyout, hresp}, 32'h00000002);
        wr(8'h14, 32'hFFFFFABC);
        rdchk(8'h14, 32'h00000ABC);
        wr(8'h44, 32'hFFFFFFFF);
        rdchk(8'h44, 32'h0000FFFF);
        wr(8'h60, 32'h12345678);
        rdchk(8'h60, 32'h00000000);
        do_reset(1'b0);
        rdchk(8'h14, 32'h00000ABC);
        do_reset(1'b1);
        rdchk(8'h14, 32'h00000000);
        rdchk(8'h44, 32'h00000000);
        $display("test registers done");
    endtask
    task automatic test_dots(input logic [1:0] dc, input int bits, input logic [2:0] md, input logic sl);
        logic [11:0] pal [16];
        logic [31:0] word;
        int          n, idx;
        word = 32'h9C3A5E71;
        slow <= sl;
        for (int k = 0; k < 16; k++) begin
            pal[k] = (k < (1 << bits)) ? pval(md, k) : 12'h000;
            wr(8'(4 * k), {20'h00000, pal[k]});
        end
        wr(8'h50, {27'h0000000, md, dc});
        dots.delete();
        i_word_valid <= 1'b1;
        i_word_data <= word;
        n = 0;
        do begin @(posedge i_clk); n++; end while (o_word_ready !== 1'b1 && n < 500);
        i_word_valid <= 1'b0;
        n = 0;
        while (dots.size() < 32 / bits && n < 500) begin @(posedge i_clk); n++; end
        check(32'(dots.size()), 32'(32 / bits));
        for (int k = 0; k < 32 / bits && k < dots.size(); k++) begin
            idx = int'((word >> (k * bits)) & ((32'h1 << bits) - 32'h1));
            check({19'h00000, dots[k]}, {19'h00000, md != 3'h6, pal[idx]});
        end
        slow <= 1'b0;
        $display("test dots depth %0d mode %0d done", bits, md);
    endtask
    task automatic test_fetch(input logic lower, input logic [31:0] base);
        int n;
        wr(lower ? 8'h48 : 8'h40, {16'h0000, base[15:0]});
        wr(lower ? 8'h4C : 8'h44, {16'h0000, base[31:16]});
        wr(8'h50, {26'h0000000, lower, 5'h02});
        beats.delete();
        i_fetch_start <= 1'b1;
        i_fetch_lower <= lower;
        @(posedge i_clk);
        i_fetch_start <= 1'b0;
        n = 0;
        while (beats.size() < 4 && n < 200) begin @(posedge i_clk); n++; end
        repeat (3) @(posedge i_clk);
        check(32'(beats.size()), 32'h00000004);
        check({31'h0, o_fetch_req}, 32'h00000000);
        for (int k = 0; k < 4 && k < beats.size(); k++)
            check({1'b0, beats[k]}, {1'b0, 2'(k), base[28:0] + 29'(4 * k)});
        $display("test fetch lower %0d done", lower);
    endtask
    // ==========================================================
    // closing
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(8 * 20000);
        n_errors++;
        complete_run();
    end
    initial begin
        {hsel, hwrite, i_word_valid, i_fetch_start, i_fetch_lower, slow} = 6'h00;
        {haddr, hwdata, i_word_data} = '0;
        htrans = 2'h0;
        hsize = 3'h2;
        i_nrst = 1'b0;
        i_por = 1'b1;
        n_errors = 0;
        checks = 0;
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        i_por <= 1'b0;
        @(posedge i_clk);
        test_regs();
        test_dots(ppf_pkg::DEPTH_1BIT, 1, 3'h0, 1'b0);
        test_dots(ppf_pkg::DEPTH_2BIT, 2, ppf_pkg::MODE_STN_COLOR, 1'b0);
        test_dots(ppf_pkg::DEPTH_4BIT, 4, 3'h1, 1'b1);
        test_dots(ppf_pkg::DEPTH_4BIT, 4, ppf_pkg::MODE_THIN_FILM, 1'b1);
        test_fetch(1'b0, 32'hE1234560);
        slow <= 1'b1;
        test_fetch(1'b1, 32'hA007FFF0);
        complete_run();
    end
endmodule
`default_nettype wire
